// file: hw/cms_pkg.sv
// Package for the charge mode sequencer: states, carriers, timing constants.
// Assumes a single 50 MHz clock domain.
package cms_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned SUPPLY_QUAL_MS  = 1000;
    localparam int unsigned SUPPLY_QUAL_CYC = (CLK_HZ / 1000) * SUPPLY_QUAL_MS;
    // 0.8 Hz blink: half period 625 ms
    localparam int unsigned BLINK_HALF_MS   = 625;
    localparam int unsigned BLINK_HALF_CYC  = (CLK_HZ / 1000) * BLINK_HALF_MS;
    localparam int unsigned CNT_W           = 32;

    // Reset values
    localparam logic        PASS_RST  = 1'b0;
    localparam logic        OE_N_RST  = 1'b1;
    // Open-drain pads only ever pull low
    localparam logic        OD_DATA   = 1'b0;

    // Analog level selections (millivolt codes fed to the analog side)
    localparam logic [15:0] TERM_LO_MV  = 16'h1004; // 4100
    localparam logic [15:0] FLOAT_LO_MV = 16'h0F00; // 3840
    localparam logic [15:0] OV_LO_MV    = 16'h10CC; // 4300
    localparam logic [15:0] TERM_HI_MV  = 16'h1068; // 4200
    localparam logic [15:0] FLOAT_HI_MV = 16'h0FFA; // 4090
    localparam logic [15:0] OV_HI_MV    = 16'h1130; // 4400
    localparam logic [15:0] SENSE_FAST_MV  = 16'h01F4; // 500
    localparam logic [15:0] SENSE_BOOST_MV = 16'h0384; // 900

    typedef enum logic [2:0] {
        CMS_RESET,
        CMS_STANDBY,
        CMS_CHARGE,
        CMS_BOOST,
        CMS_FAULT
    } cms_state_t;

    typedef struct packed {
        logic pack_enable;
        logic boost;
        logic charge_int_n;
        logic volt_select;
    } cms_ctrl_t;

    typedef struct packed {
        logic supply_above_start;
        logic supply_below_reset;
        logic over_voltage;
        logic over_current;
    } cms_cmp_t;

    typedef struct packed {
        logic [15:0] term_mv;
        logic [15:0] float_mv;
        logic [15:0] ov_mv;
        logic [15:0] sense_limit_mv;
    } cms_levels_t;

endpackage

// file: hw/cms_sequencer.sv
// Charge mode sequencer: reset hold, standby, charge, boost and fault control.
// Assumes control inputs and comparator results are synchronous to i_clk.
`timescale 1ns/1ps
module cms_sequencer
    import cms_pkg::*;
#(
    parameter int unsigned QUAL_CYC  = cms_pkg::SUPPLY_QUAL_CYC,
    parameter int unsigned BLINK_CYC = cms_pkg::BLINK_HALF_CYC
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_reset_n,
    // Control inputs and comparators
    input  wire cms_pkg::cms_ctrl_t   i_ctrl,
    input  wire cms_pkg::cms_cmp_t    i_cmp,
    // Drive and indicators (indicators open drain, enable low drives)
    output logic                      o_pass_drive_out,
    output logic                      o_status_indicator_a_o,
    output logic                      o_status_indicator_a_oe_n,
    output logic                      o_status_indicator_b_o,
    output logic                      o_status_indicator_b_oe_n,
    // Analog setpoints and state
    output cms_pkg::cms_levels_t      o_levels,
    output cms_pkg::cms_state_t       o_state
);
    import cms_pkg::*;

    cms_ctrl_t   ctrl_q;
    cms_cmp_t    cmp_q;
    cms_state_t  state_q, state_d;
    logic [CNT_W-1:0] qual_q, qual_d;
    logic [CNT_W-1:0] blink_cnt_q, blink_cnt_d;
    logic        blink_q, blink_d;
    logic        pass_q, pass_d;
    logic        ind_oe_a_q, ind_oe_a_d;
    logic        ind_oe_b_q, ind_oe_b_d;
    cms_levels_t lev_q, lev_d;
    logic        ind_dat_q;

    // One stage only: pins are already synchronous to i_clk
    // input registering
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= '0;
            cmp_q  <= '0;
        end else begin
            ctrl_q <= i_ctrl;
            cmp_q  <= i_cmp;
        end
    end

    always_comb begin
        state_d     = state_q;
        qual_d      = qual_q;
        case (state_q)
            CMS_RESET: begin
                if (!cmp_q.supply_above_start) begin
                    qual_d = '0;
                end else if (qual_q >= CNT_W'(QUAL_CYC - 1)) begin
                    qual_d  = '0;
                    state_d = CMS_STANDBY;
                end else begin
                    qual_d = qual_q + 1'b1;
                end
            end
            CMS_STANDBY: begin
                if (ctrl_q.boost && ctrl_q.charge_int_n) begin
                    state_d = CMS_BOOST;
                end else if (ctrl_q.pack_enable) begin
                    state_d = CMS_CHARGE;
                end
            end
            CMS_CHARGE, CMS_BOOST: begin
                if (cmp_q.over_voltage || cmp_q.over_current) begin
                    state_d = CMS_FAULT;
                end else if (ctrl_q.boost && ctrl_q.charge_int_n) begin
                    state_d = CMS_BOOST;
                end else if (ctrl_q.pack_enable) begin
                    state_d = CMS_CHARGE;
                end else if (!ctrl_q.boost) begin
                    state_d = CMS_STANDBY;
                end
            end
            CMS_FAULT: begin
                if (!ctrl_q.pack_enable) begin
                    state_d = CMS_STANDBY;
                end
            end
            default: state_d = CMS_RESET;
        endcase
        if (state_q != CMS_RESET && cmp_q.supply_below_reset) begin
            state_d = CMS_RESET;
            qual_d  = '0;
        end
    end

    // Sequencer state: reset hold and qualification count
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= CMS_RESET;
            qual_q  <= '0;
        end else begin
            state_q <= state_d;
            qual_q  <= qual_d;
        end
    end

    // 0.8 Hz blink timer, phase restarts on each fault entry
    always_comb begin
        blink_cnt_d = blink_cnt_q;
        blink_d     = blink_q;
        if (state_q == CMS_FAULT) begin
            if (blink_cnt_q >= CNT_W'(BLINK_CYC - 1)) begin
                blink_cnt_d = '0;
                blink_d     = ~blink_q;
            end else begin
                blink_cnt_d = blink_cnt_q + 1'b1;
            end
        end else begin
            blink_cnt_d = '0;
            blink_d     = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
        end else begin
            blink_cnt_q <= blink_cnt_d;
            blink_q     <= blink_d;
        end
    end

    // Outputs are decoded from next state so they leave flops aligned with it
    always_comb begin
        pass_d     = 1'b0;
        ind_oe_a_d = 1'b1;
        ind_oe_b_d = 1'b1;
        case (state_d)
            CMS_RESET: pass_d = 1'b0;
            CMS_STANDBY: pass_d = 1'b0;
            CMS_CHARGE: begin
                pass_d     = ctrl_q.charge_int_n;
                ind_oe_a_d = 1'b0;
            end
            CMS_BOOST: begin
                pass_d     = ctrl_q.charge_int_n;
                ind_oe_a_d = 1'b0;
                ind_oe_b_d = 1'b0;
            end
            CMS_FAULT: begin
                pass_d     = 1'b0;
                ind_oe_a_d = ~blink_d;
                ind_oe_b_d = ~blink_d;
            end
            default: pass_d = 1'b0;
        endcase
        if (!ctrl_q.volt_select) begin
            lev_d.term_mv  = TERM_LO_MV;
            lev_d.float_mv = FLOAT_LO_MV;
            lev_d.ov_mv    = OV_LO_MV;
        end else begin
            lev_d.term_mv  = TERM_HI_MV;
            lev_d.float_mv = FLOAT_HI_MV;
            lev_d.ov_mv    = OV_HI_MV;
        end
        lev_d.sense_limit_mv = (state_d == CMS_BOOST) ? SENSE_BOOST_MV : SENSE_FAST_MV;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ind_dat_q   <= OD_DATA;
            pass_q      <= PASS_RST;
            ind_oe_a_q  <= OE_N_RST;
            ind_oe_b_q  <= OE_N_RST;
            lev_q       <= {TERM_LO_MV, FLOAT_LO_MV, OV_LO_MV, SENSE_FAST_MV};
        end else begin
            ind_dat_q   <= OD_DATA;
            pass_q      <= pass_d;
            ind_oe_a_q  <= ind_oe_a_d;
            ind_oe_b_q  <= ind_oe_b_d;
            lev_q       <= lev_d;
        end
    end

    assign o_pass_drive_out          = pass_q;
    // Open-drain data sits in a flop too, so every pin leaves a register
    assign o_status_indicator_a_o    = ind_dat_q;
    assign o_status_indicator_a_oe_n = ind_oe_a_q;
    assign o_status_indicator_b_o    = ind_dat_q;
    assign o_status_indicator_b_oe_n = ind_oe_b_q;
    assign o_levels                  = lev_q;
    assign o_state                   = state_q;

endmodule // cms_sequencer

// file: verification/cms_ctrl_model.sv
// Control-side partner: drives the four control inputs.
// Assumes the bench sets wanted levels just after a rising edge.
`timescale 1ns/1ps
module cms_ctrl_model
    import cms_pkg::*;
(
    input  wire cms_pkg::cms_ctrl_t i_want,
    output cms_pkg::cms_ctrl_t      o_ctrl
);
    always_comb o_ctrl = $isunknown(i_want) ? 4'h2 : i_want;
endmodule // cms_ctrl_model

// file: verification/cms_sequencer_assertions.sv
// Checker for the charge mode sequencer ports.
// Assumes the two-edge input-to-output latency of the sequencer.
`timescale 1ns/1ps
module cms_sequencer_assertions
    import cms_pkg::*;
#(
    parameter int unsigned QUAL_CYC = 20
) (
    input wire logic                i_clk,
    input wire logic                i_reset_n,
    input wire cms_pkg::cms_ctrl_t  i_ctrl,
    input wire cms_pkg::cms_cmp_t   i_cmp,
    input wire logic                o_pass_drive_out,
    input wire logic                o_status_indicator_a_oe_n,
    input wire logic                o_status_indicator_b_oe_n,
    input wire cms_pkg::cms_levels_t o_levels,
    input wire cms_pkg::cms_state_t  o_state
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Consecutive cycles the supply has been seen good
    logic [31:0] up_cnt_q;
    logic [31:0] up_cnt_d;
    always_comb up_cnt_d = i_cmp.supply_above_start ? up_cnt_q + 32'h1 : 32'h0;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) up_cnt_q <= 32'h0;
        else up_cnt_q <= up_cnt_d;
    end
    a_qual_time: assert property ($past(o_state) == CMS_RESET && o_state == CMS_STANDBY |-> up_cnt_q > QUAL_CYC)
        else $error("standby entered before supply qualified");
    a_brownout_reset: assert property (i_cmp.supply_below_reset |-> ##2 o_state == CMS_RESET)
        else $error("no reset after brown-out");
    a_reset_pass_low: assert property (o_state == CMS_RESET |-> !o_pass_drive_out)
        else $error("pass drive on in reset");
    a_int_drive_off: assert property (!i_ctrl.charge_int_n |-> ##2 !o_pass_drive_out)
        else $error("pass drive on while interrupted");
    a_int_blocks_boost: assert property ($rose(o_state == CMS_BOOST) |-> $past(i_ctrl.charge_int_n, 2))
        else $error("boost entered while interrupted");
    a_boost_sense: assert property (o_state == CMS_BOOST |-> o_levels.sense_limit_mv == SENSE_BOOST_MV)
        else $error("boost sense level wrong");
    a_boost_leds: assert property (o_state == CMS_BOOST |-> !o_status_indicator_a_oe_n && !o_status_indicator_b_oe_n)
        else $error("indicators not low in boost");
    a_standby_idle: assert property (o_state == CMS_STANDBY |-> o_status_indicator_a_oe_n && o_status_indicator_b_oe_n && !o_pass_drive_out)
        else $error("standby outputs wrong");
    a_vsel_high: assert property (i_ctrl.volt_select |-> ##2 o_levels[63:16] == {TERM_HI_MV, FLOAT_HI_MV, OV_HI_MV})
        else $error("high select levels wrong");
    a_vsel_low: assert property (!i_ctrl.volt_select |-> ##2 o_levels[63:16] == {TERM_LO_MV, FLOAT_LO_MV, OV_LO_MV})
        else $error("low select levels wrong");
    a_fault_exit: assert property ($past(o_state) == CMS_FAULT && o_state != CMS_FAULT |-> !$past(i_ctrl.pack_enable, 2) || $past(i_cmp.supply_below_reset, 2))
        else $error("fault left with pack enabled");
endmodule // cms_sequencer_assertions
bind cms_sequencer cms_sequencer_assertions #(.QUAL_CYC(QUAL_CYC)) cms_sequencer_assertions_inst (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ctrl(i_ctrl), .i_cmp(i_cmp), .o_pass_drive_out(o_pass_drive_out),
    .o_status_indicator_a_oe_n(o_status_indicator_a_oe_n), .o_status_indicator_b_oe_n(o_status_indicator_b_oe_n),
    .o_levels(o_levels), .o_state(o_state));

// file: verification/tb_charge_mode_sequencer.sv
// Bench for the charge mode sequencer: random control traffic plus corner cases.
// Assumes shortened qualification and blink counts.
`timescale 1ns/1ps
module tb_charge_mode_sequencer;
    import cms_pkg::*;
    localparam int unsigned QC = 20;
    logic        i_clk = 1'b0, i_reset_n = 1'b0, pass, a_oe_n, b_oe_n, lo, hi, a_od, b_od;
    cms_ctrl_t   want = 4'h2, ctrl;
    cms_cmp_t    cmp = 4'h0;
    cms_levels_t lv;
    cms_state_t  st, es;
    logic [31:0] rnd;
    int          seed = 72, n_mismatch = 0, check_count = 0;
    cms_ctrl_model cms_ctrl_model_inst (.i_want(want), .o_ctrl(ctrl));
    cms_sequencer #(.QUAL_CYC(QC), .BLINK_CYC(4)) cms_sequencer_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_ctrl(ctrl), .i_cmp(cmp), .o_pass_drive_out(pass), .o_status_indicator_a_o(a_od),
        .o_status_indicator_a_oe_n(a_oe_n), .o_status_indicator_b_o(b_od), .o_status_indicator_b_oe_n(b_oe_n),
        .o_levels(lv), .o_state(st));
    initial forever #10 i_clk = ~i_clk;
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic wait_st(input cms_state_t s);
        for (int k = 0; k < 60 && st !== s; k++) cyc(1);
        chk(st, s);
        if (st !== s) tally_and_finish();
    endtask
    function automatic cms_state_t nxt(cms_state_t s, cms_ctrl_t c);
        if (c.boost && c.charge_int_n) return CMS_BOOST;
        if (c.pack_enable) return CMS_CHARGE;
        if (s == CMS_STANDBY || !c.boost) return CMS_STANDBY;
        return s;
    endfunction
    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        cmp <= 4'h8;
        repeat (10) @(posedge i_clk);
        cmp <= 4'h0;
        @(posedge i_clk);
        cmp <= 4'h8;
        cyc(QC - 2);
        chk(st, CMS_RESET);
        chk(pass, 1'b0);
        wait_st(CMS_STANDBY);
        es = CMS_STANDBY;
        for (int i = 0; i < 150; i++) begin
            rnd = $random(seed);
            @(posedge i_clk);
            want <= (i == 0) ? 4'h0 : (i == 1) ? 4'h4 : rnd[3:0];
            cyc(4);
            es = nxt(es, ctrl);
            chk(st, es);
            chk(pass, (es == CMS_CHARGE || es == CMS_BOOST) && ctrl.charge_int_n);
            chk({a_oe_n, b_oe_n}, {es == CMS_STANDBY, es != CMS_BOOST});
            chk({a_od, b_od}, 2'h0);
            chk(lv, {ctrl.volt_select ? {TERM_HI_MV, FLOAT_HI_MV, OV_HI_MV} : {TERM_LO_MV, FLOAT_LO_MV, OV_LO_MV},
                es == CMS_BOOST ? SENSE_BOOST_MV : SENSE_FAST_MV});
        end
        for (int f = 0; f < 2; f++) begin
            @(posedge i_clk);
            want <= 4'hA;
            cmp <= f ? 4'h9 : 4'hA;
            wait_st(CMS_FAULT);
            @(posedge i_clk);
            cmp <= 4'h8;
            lo = 1'b0;
            hi = 1'b0;
            repeat (12) begin
                cyc(1);
                chk({st, pass, a_oe_n}, {CMS_FAULT, 1'b0, b_oe_n});
                lo |= !a_oe_n;
                hi |= a_oe_n;
            end
            chk({lo, hi}, 2'h3);
            @(posedge i_clk);
            want <= 4'h2;
            wait_st(CMS_STANDBY);
        end
        @(posedge i_clk);
        want <= 4'hA;
        cmp <= 4'h4;
        wait_st(CMS_RESET);
        chk(pass, 1'b0);
        tally_and_finish();
    end
endmodule // tb_charge_mode_sequencer
